//--- core/twsl_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - half_rate_clock_out is master clock divided by 2, always running
// R2 - eighth_rate_clock_out is master clock divided by 8
// R3 - each rising shift clock edge shifts serial data into 16-bit register
// R4 - host sends least significant bit first, most significant bit last
// R5 - falling latch strobe edge copies shift register into holding latch
// R6 - host drops latch strobe only while shift clock is low
// R7 - host keeps latch strobe low during shifting
// R8 - shift and latch act on edges only, never levels
// R9 - zero-detect is asserted whenever all shift register bits are zero
// R10 - mode high: power-down when register zero and strobe high
// R11 - mode low: power-down unconditionally
// R12 - power-down zeroes sine output; clocks, shift register, latch keep running
// R13 - analog output is zero volts during power-down
// R14 - inhibit level: inhibit when register zero and strobe high
// R15 - inhibit finishes current half cycle, then holds at zero crossing
// R16 - holding word is added to phase accumulator every 4 clocks
// R17 - tone frequency is clock times word over 2^23
// R18 - accumulator addresses sine table feeding the converter
// R19 - mode pin arrives as two decoded inputs: power-down and inhibit
// R20 - reset clears shift register, latch, accumulator and divider counters
module twsl_core #(
    parameter int WORD_W = twsl_pkg::WORD_W,
    parameter int ACC_W = twsl_pkg::ACC_W
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic serial_data_in,
    input wire logic shift_clock_in,
    input wire logic latch_strobe_in,
    input wire logic mode_pdn_force_in,
    input wire logic mode_inhibit_in,
    output logic half_rate_clock_out,
    output logic eighth_rate_clock_out,
    output logic [twsl_pkg::SAMPLE_W-1:0] analog_output,
    output logic zero_detect_out,
    output logic power_down_out,
    output logic inhibit_out,
    output logic [WORD_W-1:0] freq_word_out
);
    initial begin
        if (WORD_W != 16 || ACC_W != WORD_W + 5) begin
            $error("twsl_core: needs 16-bit word and 21-bit accumulator");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] div_cnt;
        logic sck_d;
        logic lat_d;
        logic [WORD_W-1:0] shreg;
        logic [WORD_W-1:0] latch;
        logic [ACC_W-1:0] acc;
        twsl_pkg::twsl_mode_t mode;
        logic half_clk;
        logic eighth_clk;
        logic zero_det;
        logic pdn;
        logic inh;
        logic [twsl_pkg::SAMPLE_W-1:0] aout;
        logic [WORD_W-1:0] word;
    } twsl_state_t;

    localparam twsl_state_t ST_RST = '{
        div_cnt: twsl_pkg::DIV_CNT_RST,
        sck_d: 1'b0,
        lat_d: 1'b0,
        shreg: twsl_pkg::WORD_RST,
        latch: twsl_pkg::WORD_RST,
        acc: twsl_pkg::ACC_RST,
        mode: twsl_pkg::TWSL_RUN,
        half_clk: 1'b0,
        eighth_clk: 1'b0,
        zero_det: 1'b1,
        pdn: 1'b0,
        inh: 1'b0,
        aout: twsl_pkg::SAMPLE_ZERO,
        word: twsl_pkg::WORD_RST
    };

    twsl_state_t st_r;
    twsl_state_t st_nxt;
    logic [twsl_pkg::SAMPLE_W-1:0] sample;

    ////////////////////////////////////////////////////////////////////////
    twsl_sine_rom u_rom (
        .clk_in(clk_in),
        .addr_in(st_r.acc[ACC_W-1 -: twsl_pkg::LUT_AW]), // R18
        .data_out(sample)
    );

    ////////////////////////////////////////////////////////////////////////
    logic sck_rise;
    logic lat_fall;
    logic zero_now;
    logic arm;
    logic [ACC_W-1:0] acc_sum;
    always_comb begin
        st_nxt = st_r;
        // edge detection against last sample; levels never move data
        sck_rise = shift_clock_in && !st_r.sck_d; // R8
        lat_fall = !latch_strobe_in && st_r.lat_d; // R8
        st_nxt.sck_d = shift_clock_in;
        st_nxt.lat_d = latch_strobe_in;
        st_nxt.div_cnt = st_r.div_cnt + 3'h1;
        // dividers run in every mode
        st_nxt.half_clk = st_nxt.div_cnt[0]; // R1 R12
        st_nxt.eighth_clk = st_nxt.div_cnt[2]; // R2 R12
        if (sck_rise) begin
            // new bit enters at the top, so first bit ends at lsb
            st_nxt.shreg = {serial_data_in, st_r.shreg[WORD_W-1:1]}; // R3 R4
        end
        if (lat_fall) begin
            st_nxt.latch = st_r.shreg; // R5
        end
        zero_now = (st_nxt.shreg == '0);
        st_nxt.zero_det = zero_now; // R9
        arm = zero_now && latch_strobe_in;
        acc_sum = st_r.acc + {5'h00, st_r.latch};
        if (st_r.div_cnt[1:0] == 2'h3) begin
            st_nxt.acc = acc_sum; // R16 R17
        end
        case (st_r.mode)
            twsl_pkg::TWSL_RUN: begin
                if (mode_pdn_force_in) begin
                    st_nxt.mode = twsl_pkg::TWSL_PDN; // R11 R19
                end else if (mode_inhibit_in && arm) begin
                    st_nxt.mode = twsl_pkg::TWSL_INH_WAIT; // R14 R19
                end else if (!mode_inhibit_in && arm) begin
                    st_nxt.mode = twsl_pkg::TWSL_PDN; // R10
                end
            end
            twsl_pkg::TWSL_INH_WAIT: begin
                // wait for the half cycle to end at a zero crossing
                if (mode_pdn_force_in) begin
                    st_nxt.mode = twsl_pkg::TWSL_PDN;
                end else if (!arm) begin
                    st_nxt.mode = twsl_pkg::TWSL_RUN;
                end else if (!mode_inhibit_in) begin
                    // pin left the inhibit level while still armed
                    st_nxt.mode = twsl_pkg::TWSL_PDN; // R10
                end else if (sample == twsl_pkg::SAMPLE_ZERO) begin
                    st_nxt.mode = twsl_pkg::TWSL_INH_HOLD; // R15
                end
            end
            twsl_pkg::TWSL_INH_HOLD: begin
                if (mode_pdn_force_in) begin
                    st_nxt.mode = twsl_pkg::TWSL_PDN;
                end else if (!arm) begin
                    st_nxt.mode = twsl_pkg::TWSL_RUN;
                end else if (!mode_inhibit_in) begin
                    st_nxt.mode = twsl_pkg::TWSL_PDN; // R10
                end
            end
            twsl_pkg::TWSL_PDN: begin
                if (!mode_pdn_force_in && !(arm && !mode_inhibit_in)) begin
                    st_nxt.mode = twsl_pkg::TWSL_RUN;
                end
            end
            default: st_nxt.mode = twsl_pkg::TWSL_RUN;
        endcase
        st_nxt.pdn = (st_nxt.mode == twsl_pkg::TWSL_PDN);
        st_nxt.inh = (st_nxt.mode == twsl_pkg::TWSL_INH_HOLD);
        // zero in power-down or once held at the crossing
        if (st_nxt.pdn || st_nxt.inh) begin
            st_nxt.aout = twsl_pkg::SAMPLE_ZERO; // R12 R13 R15
        end else begin
            st_nxt.aout = sample; // R18
        end
        st_nxt.word = st_nxt.latch;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= ST_RST; // R20
        end else begin
            st_r <= st_nxt;
        end
    end

    assign half_rate_clock_out = st_r.half_clk;
    assign eighth_rate_clock_out = st_r.eighth_clk;
    assign analog_output = st_r.aout;
    assign zero_detect_out = st_r.zero_det;
    assign power_down_out = st_r.pdn;
    assign inhibit_out = st_r.inh;
    assign freq_word_out = st_r.word;

    ////////////////////////////////////////////////////////////////////////
    property p_half;
        @(posedge clk_in) disable iff (sys_rst_in)
        half_rate_clock_out |=> !half_rate_clock_out ##1 half_rate_clock_out;
    endproperty
    a_half: assert property (p_half) else $error("half clock not /2"); // R1
    property p_eighth;
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(eighth_rate_clock_out) |-> eighth_rate_clock_out[*4]
            ##1 !eighth_rate_clock_out[*4] ##1 eighth_rate_clock_out;
    endproperty
    a_eighth: assert property (p_eighth) else $error("eighth clock bad"); // R2
    property p_shift;
        @(posedge clk_in) disable iff (sys_rst_in)
        sck_rise |=> st_r.shreg[WORD_W-1] == $past(serial_data_in);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted"); // R3
    property p_latch;
        @(posedge clk_in) disable iff (sys_rst_in)
        lat_fall |=> st_r.latch == $past(st_r.shreg) ##1
            freq_word_out == $past(st_r.shreg, 2);
    endproperty
    a_latch: assert property (p_latch) else $error("latch missed"); // R5
    property p_level;
        @(posedge clk_in) disable iff (sys_rst_in)
        (shift_clock_in && st_r.sck_d && !lat_fall) |=> $stable(st_r.shreg);
    endproperty
    a_level: assert property (p_level) else $error("level shifted"); // R8
    property p_zero;
        @(posedge clk_in) disable iff (sys_rst_in)
        zero_detect_out == (st_r.shreg == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero detect wrong"); // R9
    property p_force;
        @(posedge clk_in) disable iff (sys_rst_in)
        mode_pdn_force_in |=> power_down_out && analog_output == 8'h00;
    endproperty
    a_force: assert property (p_force) else $error("no forced pdn"); // R11
    property p_pdn_hi;
        @(posedge clk_in) disable iff (sys_rst_in)
        (!mode_inhibit_in && arm) |=> power_down_out;
    endproperty
    a_pdn_hi: assert property (p_pdn_hi) else $error("no zero pdn"); // R10
    property p_acc;
        @(posedge clk_in) disable iff (sys_rst_in)
        st_r.div_cnt[1:0] != 2'h3 |=> $stable(st_r.acc);
    endproperty
    a_acc: assert property (p_acc) else $error("acc stepped early"); // R16
    property p_inh;
        @(posedge clk_in) disable iff (sys_rst_in)
        inhibit_out |-> analog_output == 8'h00 && !power_down_out;
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit not held"); // R15
endmodule : twsl_core
`default_nettype wire

//--- core/twsl_pkg.sv
package twsl_pkg;
    // frequency word and shift register width
    localparam int WORD_W = 16;
    // phase accumulator: 16-bit word added every 4 clocks, overflow at 2^21
    // per add, so f_out = f_clk * word / 2^23
    localparam int ACC_W = 21;
    // sine table address and sample width
    localparam int LUT_AW = 6;
    localparam int SAMPLE_W = 8;
    // master clock dividers
    localparam int HALF_DIV = 2;
    localparam int EIGHTH_DIV = 8;
    localparam int ADD_DIV = 4;
    localparam logic [2:0] DIV_CNT_RST = 3'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_RST = 21'h000000;
    // output code of zero volts (two's complement sample)
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        TWSL_RUN = 2'b00,
        TWSL_INH_WAIT = 2'b01,
        TWSL_INH_HOLD = 2'b10,
        TWSL_PDN = 2'b11
    } twsl_mode_t;
endpackage : twsl_pkg

//--- core/twsl_sine_rom.sv
`timescale 1ns/1ps
`default_nettype none
module twsl_sine_rom #(
    parameter int ADDR_W = twsl_pkg::LUT_AW,
    parameter int DATA_W = twsl_pkg::SAMPLE_W
) (
    input wire logic clk_in,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [DATA_W-1:0] data_out
);
    initial begin
        if (ADDR_W != 6 || DATA_W != 8) begin
            $error("twsl_sine_rom: table is built for 64 x 8 only");
        end
    end

    // quarter-wave table, 16 entries, mirrored for the full cycle
    function automatic logic [6:0] quarter(input logic [3:0] i);
        case (i)
            4'h0: quarter = 7'h00;
            4'h1: quarter = 7'h0C;
            4'h2: quarter = 7'h19;
            4'h3: quarter = 7'h25;
            4'h4: quarter = 7'h31;
            4'h5: quarter = 7'h3C;
            4'h6: quarter = 7'h47;
            4'h7: quarter = 7'h51;
            4'h8: quarter = 7'h5A;
            4'h9: quarter = 7'h62;
            4'hA: quarter = 7'h6A;
            4'hB: quarter = 7'h70;
            4'hC: quarter = 7'h75;
            4'hD: quarter = 7'h79;
            4'hE: quarter = 7'h7C;
            4'hF: quarter = 7'h7E;
            default: quarter = 7'h00;
        endcase
    endfunction : quarter

    logic [3:0] idx;
    logic [6:0] mag;
    always_comb begin
        idx = addr_in[4] ? ~addr_in[3:0] : addr_in[3:0];
        // mirrored index 0 of the falling quarter is the peak, not zero
        mag = (addr_in[4] && addr_in[3:0] == 4'h0) ? 7'h7F : quarter(idx);
    end

    always_ff @(posedge clk_in) begin
        data_out <= addr_in[5] ? 8'(-{1'b0, mag}) : {1'b0, mag};
    end
endmodule : twsl_sine_rom
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic pdn = 1'b0;
    logic inh = 1'b0;
    logic sd, sck, lat, half, eighth, zd, pd, ih;
    logic [twsl_pkg::SAMPLE_W-1:0] aout;
    logic [15:0] fw;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #20 clk_in = ~clk_in;
    twsl_host host_u (.clk_in(clk_in), .sdata_out(sd), .sclk_out(sck),
        .latch_out(lat));
    twsl_core dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .serial_data_in(sd), .shift_clock_in(sck), .latch_strobe_in(lat),
        .mode_pdn_force_in(pdn), .mode_inhibit_in(inh),
        .half_rate_clock_out(half), .eighth_rate_clock_out(eighth),
        .analog_output(aout), .zero_detect_out(zd), .power_down_out(pd),
        .inhibit_out(ih), .freq_word_out(fw));
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    task automatic t_clocks;
        logic prev;
        logic [7:0] v;
        prev = half;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            chk(half, !prev);
            prev = half;
        end
        while (eighth !== 1'b0) tick(1);
        while (eighth !== 1'b1) tick(1);
        // a divide-by-4 would show 8'h99 here
        for (int i = 0; i < 8; i++) begin
            tick(1);
            v[i] = eighth;
        end
        chk(v, 8'h87);
    endtask : t_clocks
    task automatic t_load;
        host_u.send_word(16'hA5C3, 1'b0);
        chk(fw, 16'hA5C3);
        chk(zd, 1'b0);
        host_u.send_word(16'h1234, 1'b1);
        tick(20);
        chk(fw, 16'hA5C3);
        host_u.drop_latch;
        chk(fw, 16'h1234);
    endtask : t_load
    task automatic t_tone;
        int n;
        host_u.send_word(16'h8000, 1'b0);
        while (aout[7] !== 1'b0) tick(1);
        while (aout[7] !== 1'b1) tick(1);
        // one full period: sign bit falls, then rises again
        n = 0;
        while (aout[7] !== 1'b0 && n < 600) begin
            tick(1);
            n++;
        end
        while (aout[7] !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        // 2^21 / 2^15 adds, one add per 4 clocks
        chk(n, 256);
    endtask : t_tone
    task automatic t_inhibit;
        int n;
        inh = 1'b1;
        host_u.send_word(16'h0000, 1'b1);
        n = 0;
        while (ih !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        chk(ih, 1'b1);
        chk(aout, 8'h00);
        tick(100);
        chk(aout, 8'h00);
        chk(pd, 1'b0);
        host_u.drop_latch;
        inh = 1'b0;
    endtask : t_inhibit
    task automatic t_pdn;
        logic prev;
        host_u.send_word(16'h0000, 1'b1);
        chk(pd, 1'b1);
        chk(aout, 8'h00);
        prev = half;
        tick(1);
        chk(half, !prev);
        host_u.drop_latch;
        chk(pd, 1'b0);
        pdn = 1'b1;
        tick(2);
        chk(pd, 1'b1);
        host_u.send_word(16'h0F0F, 1'b0);
        chk(fw, 16'h0F0F);
        chk(aout, 8'h00);
        pdn = 1'b0;
        tick(2);
        chk(pd, 1'b0);
    endtask : t_pdn
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report;
        end
    end
    initial begin
        tick(20);
        sys_rst_in = 1'b0;
        chk(fw, 16'h0000);
        chk(zd, 1'b1);
        chk(aout, 8'h00);
        t_clocks;
        t_load;
        t_tone;
        t_inhibit;
        t_pdn;
        final_report;
    end
endmodule : tb
`default_nettype wire

//--- tb/twsl_host.sv
`timescale 1ns/1ps
`default_nettype none
module twsl_host (
    input wire logic clk_in,
    output logic sdata_out,
    output logic sclk_out,
    output logic latch_out
);
    initial begin
        sdata_out = 1'b0;
        sclk_out = 1'b0;
        latch_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    ////////////////////////////////////////////////////////////////////////
    // two clocks per phase: one-clock pulses are not promised to be seen
    task automatic send_word(input logic [15:0] w, input logic hold);
        for (int i = 0; i < 16; i++) begin
            sdata_out = w[i];
            tick(2);
            sclk_out = 1'b1;
            tick(2);
            sclk_out = 1'b0;
        end
        // released data line must not keep showing the last bit
        sdata_out = ~sdata_out;
        latch_out = 1'b1;
        tick(2);
        if (!hold) begin
            latch_out = 1'b0;
        end
        tick(2);
    endtask : send_word
    task automatic drop_latch;
        latch_out = 1'b0;
        tick(2);
    endtask : drop_latch
endmodule : twsl_host
`default_nettype wire
